// File: src/call_tracker_host.sv
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`include "tracker_params.svh"
module call_tracker_host #(
    parameter int HALF = `SCLK_HALF
) (
    input  wire logic          CLK_IN,
    input  wire logic          RST_N_IN,
    pkt_link_if.host           LINK,
    input  wire logic          PSEL_IN,
    input  wire logic          PENABLE_IN,
    input  wire logic          PWRITE_IN,
    input  wire logic [7:0]    PADDR_IN,
    input  wire logic [31:0]   PWDATA_IN,
    output logic [31:0]        PRDATA_OUT,
    output logic               PREADY_OUT,
    output logic               PSLVERR_OUT
);

    // Keeps only the documented fields of an outgoing command
    function automatic logic [23:0] cmd_fields(
        input logic [31:0] w
    );
        logic [23:0] r;
        r = '0;
        r[`DAF_POS] = w[`DAF_POS];
        r[`FAF_POS] = w[`FAF_POS];
        r[15:0]     = w[15:0];
        return r;
    endfunction : cmd_fields

    logic [1:0]                      ms1_r,   ms1_nxt;
    logic [1:0]                      ms2_r,   ms2_nxt;
    call_tracker_pkg::link_state_t   st_r,    st_nxt;
    logic [15:0]                     div_r,   div_nxt;
    logic [5:0]                      bits_r,  bits_nxt;
    logic                            sclk_r,  sclk_nxt;
    logic                            csn_r,   csn_nxt;
    logic                            mosi_r,  mosi_nxt;
    call_tracker_pkg::pkt_t          sh_r,    sh_nxt;
    call_tracker_pkg::pkt_t          rxsh_r,  rxsh_nxt;
    logic                            sent_r,  sent_nxt;
    logic [23:0]                     cmd_r,   cmd_nxt;
    logic                            cmdv_r,  cmdv_nxt;
    call_tracker_pkg::pkt_t          rx_r,    rx_nxt;
    logic                            rxv_r,   rxv_nxt;
    logic [6:0]                      frame_r, frame_nxt;
    logic [7:0]                      eofs_r,  eofs_nxt;
    logic [31:0]                     prd_r,   prd_nxt;
    logic                            setup;
    logic                            access;
    logic                            mapped;
    logic                            tick;

    assign setup  = PSEL_IN & ~PENABLE_IN;
    assign access = PSEL_IN & PENABLE_IN;
    assign mapped = PADDR_IN == `OFS_CMD || PADDR_IN == `OFS_STAT
                    || PADDR_IN == `OFS_RXDATA
                    || PADDR_IN == `OFS_FRAME;
    assign tick   = div_r == 16'(HALF - 1);

    always_comb begin
        ms1_nxt   = {LINK.miso, LINK.attn};
        ms2_nxt   = ms1_r;
        st_nxt    = st_r;
        div_nxt   = tick ? 16'h0000 : div_r + 16'h0001;
        bits_nxt  = bits_r;
        sclk_nxt  = sclk_r;
        csn_nxt   = csn_r;
        mosi_nxt  = mosi_r;
        sh_nxt    = sh_r;
        rxsh_nxt  = rxsh_r;
        sent_nxt  = sent_r;
        cmd_nxt   = cmd_r;
        cmdv_nxt  = cmdv_r;
        rx_nxt    = rx_r;
        rxv_nxt   = rxv_r;
        frame_nxt = frame_r;
        eofs_nxt  = eofs_r;
        prd_nxt   = prd_r;

        // Register bus, zero wait; read data prepared in setup
        if (setup) begin
            prd_nxt = 32'h0000_0000;
            if (!PWRITE_IN) begin
                unique case (PADDR_IN)
                    `OFS_CMD:    prd_nxt = {8'h00, cmd_r};
                    `OFS_STAT:   prd_nxt = {29'h0000_0000,
                                            st_r != call_tracker_pkg::H_IDLE,
                                            rxv_r, cmdv_r};
                    `OFS_RXDATA: prd_nxt = rx_r;
                    `OFS_FRAME:  prd_nxt = {16'h0000, eofs_r,
                                            1'b0, frame_r};
                    default:     prd_nxt = 32'h0000_0000;
                endcase
            end
        end
        // A new command is ignored until the previous one has gone out
        if (access && PWRITE_IN && PADDR_IN == `OFS_CMD && !cmdv_r) begin
            cmd_nxt  = cmd_fields(PWDATA_IN);
            cmdv_nxt = 1'b1;
        end
        if (access && PWRITE_IN && PADDR_IN == `OFS_FRAME)
            eofs_nxt = 8'h00;
        if (access && !PWRITE_IN && PADDR_IN == `OFS_RXDATA)
            rxv_nxt = 1'b0;

        unique case (st_r)
            call_tracker_pkg::H_IDLE: begin
                div_nxt = 16'h0000;
                // Stall while the last packet is unread
                if (!rxv_r && (cmdv_r || ms2_r[0])) begin
                    sh_nxt   = cmdv_r ? {`ID_AFM, cmd_r}
                                      : 32'h0000_0000;
                    mosi_nxt = cmdv_r & sh_nxt[31];
                    sent_nxt = cmdv_r;
                    csn_nxt  = 1'b0;
                    bits_nxt = 6'd0;
                    st_nxt   = call_tracker_pkg::H_RUN;
                end
            end
            call_tracker_pkg::H_RUN: begin
                if (tick) begin
                    sclk_nxt = ~sclk_r;
                    if (!sclk_r) begin
                        rxsh_nxt = {rxsh_r[30:0], ms2_r[1]};
                        bits_nxt = bits_r + 6'd1;
                    end else if (bits_r == 6'd32) begin
                        st_nxt = call_tracker_pkg::H_TAIL;
                    end else begin
                        sh_nxt   = {sh_r[30:0], 1'b0};
                        mosi_nxt = sh_r[30];
                    end
                end
            end
            call_tracker_pkg::H_TAIL: begin
                if (tick) begin
                    csn_nxt  = 1'b1;
                    mosi_nxt = 1'b0;
                    st_nxt   = call_tracker_pkg::H_GAP;
                    if (sent_r)
                        cmdv_nxt = 1'b0;
                    // Idle fill from the device is not kept
                    if (rxsh_r[31:24] != `ID_IDLE) begin
                        rx_nxt  = rxsh_r;
                        rxv_nxt = 1'b1;
                    end
                    if (rxsh_r[31:24] == `ID_STATUS
                        && rxsh_r[`EOF_POS]) begin
                        frame_nxt = rxsh_r[6:0];
                        if (eofs_r != 8'hff)
                            eofs_nxt = eofs_r + 8'h01;
                    end
                end
            end
            call_tracker_pkg::H_GAP: begin
                // Gap lets the device drop its request first
                if (tick)
                    st_nxt = call_tracker_pkg::H_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ms1_r   <= 2'h0;
            ms2_r   <= 2'h0;
            st_r    <= call_tracker_pkg::H_IDLE;
            div_r   <= 16'h0000;
            bits_r  <= 6'd0;
            sclk_r  <= 1'b0;
            csn_r   <= 1'b1;
            mosi_r  <= 1'b0;
            sh_r    <= '0;
            rxsh_r  <= '0;
            sent_r  <= 1'b0;
            cmd_r   <= 24'h00_0000;
            cmdv_r  <= 1'b0;
            rx_r    <= '0;
            rxv_r   <= 1'b0;
            frame_r <= 7'h00;
            eofs_r  <= 8'h00;
            prd_r   <= 32'h0000_0000;
        end else begin
            ms1_r   <= ms1_nxt;
            ms2_r   <= ms2_nxt;
            st_r    <= st_nxt;
            div_r   <= div_nxt;
            bits_r  <= bits_nxt;
            sclk_r  <= sclk_nxt;
            csn_r   <= csn_nxt;
            mosi_r  <= mosi_nxt;
            sh_r    <= sh_nxt;
            rxsh_r  <= rxsh_nxt;
            sent_r  <= sent_nxt;
            cmd_r   <= cmd_nxt;
            cmdv_r  <= cmdv_nxt;
            rx_r    <= rx_nxt;
            rxv_r   <= rxv_nxt;
            frame_r <= frame_nxt;
            eofs_r  <= eofs_nxt;
            prd_r   <= prd_nxt;
        end
    end

    assign LINK.sclk   = sclk_r;
    assign LINK.cs_n   = csn_r;
    assign LINK.mosi   = mosi_r;
    assign PRDATA_OUT  = prd_r;
    assign PREADY_OUT  = 1'b1;
    assign PSLVERR_OUT = access & ~mapped;

endmodule : call_tracker_host

// File: src/call_tracker_pkg.sv
package call_tracker_pkg;

    typedef logic [6:0]  count_t;
    typedef logic [31:0] pkt_t;
    typedef enum {H_IDLE, H_RUN, H_TAIL, H_GAP} link_state_t;

endpackage : call_tracker_pkg

// File: src/every_frame_tracker.sv
`timescale 1ns/1ns
`include "tracker_params.svh"
module every_frame_tracker #(
    parameter int GROUPS = 16
) (
    input  wire logic                        CLK_IN,
    input  wire logic                        RST_N_IN,
    pkt_link_if.dev                          LINK,
    input  wire logic                        DECODER_ON_IN,
    input  wire logic                        CW_VALID_IN,
    input  wire logic [31:0]                 CW_DATA_IN,
    input  wire logic                        VEC_IN,
    input  wire logic [2:0]                  VEC_TYPE_IN,
    input  wire logic [2:0]                  INSTR_TYPE_IN,
    input  wire logic [$clog2(GROUPS)-1:0]   GROUP_IDX_IN,
    input  wire logic                        FRAME_END_IN,
    input  wire logic [6:0]                  FRAME_NUM_IN,
    output logic                             READY_OUT,
    output logic                             EVERY_FRAME_MODE_OUT,
    output call_tracker_pkg::count_t         FRAG_COUNT_OUT,
    output logic [GROUPS-1:0]                GROUP_ADDR_EN_OUT
);

    // Saturating step; a coinciding inc and dec cancel out
    function automatic call_tracker_pkg::count_t step(
        input call_tracker_pkg::count_t c,
        input logic                     inc,
        input logic                     dec
    );
        call_tracker_pkg::count_t r;
        r = c;
        if (inc && !dec && c != `CNT_MAX)
            r = c + 7'h01;
        if (dec && !inc && c != `CNT_ZERO)
            r = c - 7'h01;
        return r;
    endfunction : step

    logic [2:0]                 sy1_r,   sy1_nxt;
    logic [2:0]                 sy2_r,   sy2_nxt;
    logic [2:0]                 prv_r,   prv_nxt;
    call_tracker_pkg::pkt_t     tx_r,    tx_nxt;
    logic                       txv_r,   txv_nxt;
    call_tracker_pkg::pkt_t     sh_r,    sh_nxt;
    call_tracker_pkg::pkt_t     rx_r,    rx_nxt;
    logic [5:0]                 bits_r,  bits_nxt;
    logic                       snd_r,   snd_nxt;
    logic                       miso_r,  miso_nxt;
    logic                       force_r, force_nxt;
    call_tracker_pkg::count_t   frag_r,  frag_nxt;
    call_tracker_pkg::count_t   grp_r   [GROUPS];
    call_tracker_pkg::count_t   grp_nxt [GROUPS];
    logic                       mode_r,  mode_nxt;
    logic [GROUPS-1:0]          en_r,    en_nxt;
    logic                       sck_rise;
    logic                       sck_fall;
    logic                       cs_fall;
    logic                       cs_rise;
    logic                       afm_pkt;
    logic                       take_cw;
    logic                       inc_frag;
    logic                       grp_vec;

    assign sck_rise = sy2_r[0] & ~prv_r[0];
    assign sck_fall = ~sy2_r[0] & prv_r[0];
    assign cs_fall  = ~sy2_r[1] & prv_r[1];
    assign cs_rise  = sy2_r[1] & ~prv_r[1];
    // Only a complete 32-bit frame counts; short frames are dropped
    assign afm_pkt  = cs_rise && bits_r == 6'd32
                      && rx_r[31:24] == `ID_AFM;
    assign take_cw  = ~txv_r & CW_VALID_IN;
    assign grp_vec  = VEC_IN && VEC_TYPE_IN == `VT_GROUP
                      && INSTR_TYPE_IN == `IT_GROUP;
    assign inc_frag = take_cw & VEC_IN
                      & (VEC_TYPE_IN == `VT_SECURE
                         | VEC_TYPE_IN == `VT_ALPHA
                         | VEC_TYPE_IN == `VT_HEXBIN);

    always_comb begin
        sy1_nxt   = {LINK.mosi, LINK.cs_n, LINK.sclk};
        sy2_nxt   = sy1_r;
        prv_nxt   = sy2_r;
        tx_nxt    = tx_r;
        txv_nxt   = txv_r;
        sh_nxt    = sh_r;
        rx_nxt    = rx_r;
        bits_nxt  = bits_r;
        snd_nxt   = snd_r;
        miso_nxt  = miso_r;
        force_nxt = force_r;
        if (cs_fall) begin
            sh_nxt   = txv_r ? tx_r : '0;
            snd_nxt  = txv_r;
            bits_nxt = 6'd0;
            miso_nxt = txv_r & tx_r[31];
        end else if (!sy2_r[1]) begin
            if (sck_rise) begin
                rx_nxt   = {rx_r[30:0], sy2_r[2]};
                bits_nxt = bits_r + 6'd1;
            end
            if (sck_fall) begin
                sh_nxt   = {sh_r[30:0], 1'b0};
                miso_nxt = sh_r[30];
            end
        end
        if (cs_rise) begin
            snd_nxt = 1'b0;
            if (bits_r == 6'd32 && snd_r)
                txv_nxt = 1'b0;
        end
        // Single holding slot: producers wait on READY_OUT
        if (!txv_r) begin
            if (CW_VALID_IN) begin
                tx_nxt  = CW_DATA_IN;
                txv_nxt = 1'b1;
            end else if (FRAME_END_IN && mode_r) begin
                tx_nxt  = {`ID_STATUS, 7'h00, 1'b1,
                           8'h00, 1'b0, FRAME_NUM_IN};
                txv_nxt = 1'b1;
            end
        end
        if (afm_pkt)
            force_nxt = rx_r[`FAF_POS];
        frag_nxt = step(frag_r, inc_frag,
                        afm_pkt & rx_r[`DAF_POS]);
        for (int i = 0; i < GROUPS; i++) begin
            grp_nxt[i] = step(grp_r[i],
                take_cw & grp_vec
                & (GROUP_IDX_IN == ($clog2(GROUPS))'(i)),
                afm_pkt & rx_r[i]);
        end
        if (!DECODER_ON_IN) begin
            force_nxt = 1'b0;
            frag_nxt  = `CNT_ZERO;
            for (int i = 0; i < GROUPS; i++)
                grp_nxt[i] = `CNT_ZERO;
        end
        mode_nxt = force_nxt | (frag_nxt != `CNT_ZERO);
        for (int i = 0; i < GROUPS; i++) begin
            en_nxt[i] = grp_nxt[i] != `CNT_ZERO;
            mode_nxt  = mode_nxt | en_nxt[i];
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            sy1_r   <= `LINK_IDLE;
            sy2_r   <= `LINK_IDLE;
            prv_r   <= `LINK_IDLE;
            tx_r    <= '0;
            txv_r   <= 1'b0;
            sh_r    <= '0;
            rx_r    <= '0;
            bits_r  <= 6'd0;
            snd_r   <= 1'b0;
            miso_r  <= 1'b0;
            force_r <= 1'b0;
            frag_r  <= `CNT_ZERO;
            for (int i = 0; i < GROUPS; i++)
                grp_r[i] <= `CNT_ZERO;
            mode_r  <= 1'b0;
            en_r    <= '0;
        end else begin
            sy1_r   <= sy1_nxt;
            sy2_r   <= sy2_nxt;
            prv_r   <= prv_nxt;
            tx_r    <= tx_nxt;
            txv_r   <= txv_nxt;
            sh_r    <= sh_nxt;
            rx_r    <= rx_nxt;
            bits_r  <= bits_nxt;
            snd_r   <= snd_nxt;
            miso_r  <= miso_nxt;
            force_r <= force_nxt;
            frag_r  <= frag_nxt;
            for (int i = 0; i < GROUPS; i++)
                grp_r[i] <= grp_nxt[i];
            mode_r  <= mode_nxt;
            en_r    <= en_nxt;
        end
    end

    assign LINK.miso            = miso_r;
    assign LINK.attn            = txv_r;
    assign READY_OUT            = ~txv_r;
    assign EVERY_FRAME_MODE_OUT = mode_r;
    assign FRAG_COUNT_OUT       = frag_r;
    assign GROUP_ADDR_EN_OUT    = en_r;

endmodule : every_frame_tracker

// File: src/pkt_link_if.sv
`timescale 1ns/1ns
interface pkt_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic attn;

    modport dev (
        input  sclk,
        input  cs_n,
        input  mosi,
        output miso,
        output attn
    );

    modport host (
        output sclk,
        output cs_n,
        output mosi,
        input  miso,
        input  attn
    );
endinterface : pkt_link_if

// File: src/tracker_params.svh
`ifndef TRACKER_PARAMS_SVH
`define TRACKER_PARAMS_SVH

// Packet layout
`define PKT_BITS    32
`define ID_AFM      8'h03
`define ID_STATUS   8'h0e
`define ID_IDLE     8'h00
`define DAF_POS     23
`define FAF_POS     22
`define EOF_POS     16

// Vector and instruction codes
`define VT_GROUP    3'h1
`define IT_GROUP    3'h0
`define VT_SECURE   3'h0
`define VT_ALPHA    3'h5
`define VT_HEXBIN   3'h6

// Counter limits
`define CNT_MAX     7'h7f
`define CNT_ZERO    7'h00

// Link timing and idle levels
`define SCLK_HALF   8
`define LINK_IDLE   3'h2

// Host register offsets
`define OFS_CMD     8'h00
`define OFS_STAT    8'h04
`define OFS_RXDATA  8'h08
`define OFS_FRAME   8'h0c

`endif

// File: verification/link_asserts.sv
`timescale 1ns/1ns
module link_asserts (
    input  wire logic CLK_IN,
    input  wire logic RST_N_IN,
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic mosi,
    input  wire logic miso,
    input  wire logic attn
);
    logic       sclk_q_r;
    logic [5:0] rises_r;
    logic [5:0] rises_nxt;

    // Rising edges of the link clock seen inside one frame
    always_comb begin
        rises_nxt = rises_r;
        if (cs_n)
            rises_nxt = 6'h00;
        else if (sclk && !sclk_q_r)
            rises_nxt = rises_r + 6'h01;
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            sclk_q_r <= 1'b0;
            rises_r  <= 6'h00;
        end else begin
            sclk_q_r <= sclk;
            rises_r  <= rises_nxt;
        end
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    sequence high_phase;
        sclk [*8] ##1 !sclk;
    endsequence
    sequence low_phase;
        !sclk [*8];
    endsequence
    sequence frame_lead;
        !sclk [*8] ##1 sclk;
    endsequence

    a_idle_low:
        assert property (cs_n |-> !sclk)
        else $error("link clock moved while deselected");
    a_high_half:
        assert property ($rose(sclk) |-> high_phase)
        else $error("link clock high phase has wrong length");
    a_low_half:
        assert property ($fell(sclk) |-> low_phase)
        else $error("link clock low phase too short");
    a_frame_lead:
        assert property ($fell(cs_n) |-> frame_lead)
        else $error("first link clock edge misplaced");
    a_mosi_steady:
        assert property (sclk && $past(sclk) |-> $stable(mosi))
        else $error("host data moved while clock high");
    a_miso_steady:
        assert property (sclk && $past(sclk) |-> $stable(miso))
        else $error("device data moved while clock high");
    a_frame_bits:
        assert property ($rose(cs_n) |-> rises_r == 6'h20)
        else $error("frame did not carry 32 bits");
    a_frame_gap:
        assert property ($rose(cs_n) |-> cs_n [*8])
        else $error("gap between frames too short");

    c_attn: cover property ($rose(attn));
endmodule : link_asserts

// File: verification/test_all_frame_mode_call_tracker.sv
`timescale 1ns/1ns
`include "tracker_params.svh"
module test_all_frame_mode_call_tracker;
    logic                     clk, rst_n, dec_on, cw_valid, vec, frame_end;
    logic                     psel, penable, pwrite, pready, pslverr;
    logic                     ready, efm, er, sclk_q, csn_q;
    logic [7:0]               paddr;
    logic [31:0]              pwdata, prdata, cw_data, rd, seed, mi_sh, mo_sh;
    logic [2:0]               vec_type, instr_type;
    logic [3:0]               group_idx;
    logic [6:0]               frame_num;
    logic [15:0]              gen;
    call_tracker_pkg::count_t frag;
    logic [31:0]              exp_q[$], cmd_q[$];
    logic [2:0]               types[3] = '{3'h0, 3'h5, 3'h6};
    logic [3:0]               grps[4];
    int                       fails, check_count, frag_e, force_e;
    int                       cnt_e[16];

    pkt_link_if link ();
    every_frame_tracker every_frame_tracker_inst (
        .CLK_IN(clk), .RST_N_IN(rst_n), .LINK(link.dev),
        .DECODER_ON_IN(dec_on), .CW_VALID_IN(cw_valid),
        .CW_DATA_IN(cw_data), .VEC_IN(vec), .VEC_TYPE_IN(vec_type),
        .INSTR_TYPE_IN(instr_type), .GROUP_IDX_IN(group_idx),
        .FRAME_END_IN(frame_end), .FRAME_NUM_IN(frame_num),
        .READY_OUT(ready), .EVERY_FRAME_MODE_OUT(efm),
        .FRAG_COUNT_OUT(frag), .GROUP_ADDR_EN_OUT(gen));
    call_tracker_host call_tracker_host_inst (
        .CLK_IN(clk), .RST_N_IN(rst_n), .LINK(link.host),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr));
    link_asserts link_asserts_inst (
        .CLK_IN(clk), .RST_N_IN(rst_n), .sclk(link.sclk),
        .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso),
        .attn(link.attn));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction : lfsr

    function automatic logic [15:0] gmask();
        logic [15:0] g;
        for (int i = 0; i < 16; i++) g[i] = (cnt_e[i] != 0);
        return g;
    endfunction : gmask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    task automatic hang();
        fails++;
        conclude();
    endtask : hang

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, want);
        end
    endtask : chk

    // Zero-wait slave, but the master still waits on pready
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        if (n == 20) hang();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic check_model();
        logic m;
        m = (force_e != 0 || frag_e != 0 || gmask() != 16'h0);
        chk({8'h00, efm, frag, gen}, {8'h00, m, frag_e[6:0], gmask()});
    endtask : check_model

    task automatic fetch(input logic [31:0] p);
        int n;
        n = 0;
        do begin
            apb(1'b0, `OFS_STAT, 32'h0);
            n++;
        end while (rd[1] !== 1'b1 && n < 400);
        if (n == 400) hang();
        apb(1'b0, `OFS_RXDATA, 32'h0);
        chk(rd, p);
    endtask : fetch

    task automatic send(input logic [31:0] p, input logic v,
                        input logic [2:0] vt, input logic [2:0] it,
                        input logic [3:0] gi);
        int n;
        n = 0;
        cw_valid <= 1'b1;
        cw_data <= p;
        vec <= v;
        vec_type <= vt;
        instr_type <= it;
        group_idx <= gi;
        exp_q.push_back(p);
        do begin
            @(posedge clk);
            n++;
        end while (ready !== 1'b1 && n < 2000);
        if (n == 2000) hang();
        cw_valid <= 1'b0;
        if (v && (vt == `VT_SECURE || vt == `VT_ALPHA || vt == `VT_HEXBIN))
            frag_e = (frag_e < 127) ? frag_e + 1 : 127;
        if (v && vt == `VT_GROUP && it == `IT_GROUP)
            cnt_e[gi] = (cnt_e[gi] < 127) ? cnt_e[gi] + 1 : 127;
        fetch(p);
        check_model();
    endtask : send

    // Waits for the command frame to finish before checking counters
    task automatic cmd(input logic [31:0] c);
        int n;
        n = 0;
        cmd_q.push_back({`ID_AFM, c[23:22], 6'h00, c[15:0]});
        apb(1'b1, `OFS_CMD, c);
        // Second write while pending must be ignored
        apb(1'b1, `OFS_CMD, ~c);
        apb(1'b0, `OFS_CMD, 32'h0);
        chk(rd, {8'h00, c[23:22], 6'h00, c[15:0]});
        do begin
            apb(1'b0, `OFS_STAT, 32'h0);
            n++;
        end while (rd[2:0] !== 3'h0 && n < 400);
        if (n == 400) hang();
        repeat (6) @(posedge clk);
        if (c[23]) frag_e = (frag_e > 0) ? frag_e - 1 : 0;
        for (int i = 0; i < 16; i++)
            if (c[i] && cnt_e[i] > 0) cnt_e[i]--;
        force_e = c[22];
        check_model();
    endtask : cmd

    task automatic status(input logic [6:0] fr);
        int n;
        logic [31:0] p;
        n = 0;
        p = {`ID_STATUS, 7'h00, 1'b1, 8'h00, 1'b0, fr};
        frame_end <= 1'b1;
        frame_num <= fr;
        do begin
            @(posedge clk);
            n++;
        end while (ready !== 1'b1 && n < 100);
        if (n == 100) hang();
        frame_end <= 1'b0;
        if (efm === 1'b1) begin
            exp_q.push_back(p);
            fetch(p);
            apb(1'b0, `OFS_FRAME, 32'h0);
            chk({17'h0, rd[15:8], rd[6:0]}, {17'h0, 8'h01, fr});
            apb(1'b1, `OFS_FRAME, 32'h0);
        end else begin
            repeat (6) @(posedge clk);
            chk({31'h0, link.attn}, 32'h0);
        end
    endtask : status

    // Wire monitor: bits taken at link clock rise, MSB first
    always @(posedge clk) begin
        sclk_q <= link.sclk;
        csn_q <= link.cs_n;
        if (link.sclk && !sclk_q) begin
            mi_sh <= {mi_sh[30:0], link.miso};
            mo_sh <= {mo_sh[30:0], link.mosi};
        end
        if (link.cs_n && !csn_q) begin
            if (mi_sh[31:24] != 8'h00)
                chk(mi_sh, exp_q.size() ? exp_q.pop_front() : 32'h0);
            if (mo_sh[31:24] != 8'h00)
                chk(mo_sh, cmd_q.size() ? cmd_q.pop_front() : 32'h0);
        end
    end

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        repeat (95000) @(posedge clk);
        hang();
    end

    initial begin
        {rst_n, cw_valid, vec, frame_end, psel, penable, pwrite} = 7'h00;
        {sclk_q, csn_q, dec_on} = 3'h7;
        {vec_type, instr_type, group_idx, frame_num, paddr} = 25'h0;
        {pwdata, cw_data, mi_sh, mo_sh} = 128'h0;
        {fails, check_count, frag_e, force_e} = 128'h0;
        foreach (cnt_e[i]) cnt_e[i] = 0;
        seed = 32'h08a0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check_model();
        chk({31'h0, ready}, 32'h1);
        status(7'h11);
        send({8'h01, seed[23:0]}, 1'b0, 3'h0, 3'h0, 4'h0);
        send({8'h02, seed[23:0]}, 1'b1, 3'h2, 3'h0, 4'h0);
        foreach (types[i]) begin
            seed = lfsr(seed);
            send({8'h02, seed[23:0]}, 1'b1, types[i], 3'h0, 4'h0);
        end
        send({8'h02, seed[23:0]}, 1'b1, `VT_GROUP, 3'h2, 4'h3);
        seed = lfsr(seed);
        grps = '{4'h0, 4'hf, 4'hf, seed[3:0]};
        foreach (grps[i]) begin
            seed = lfsr(seed);
            send({8'h02, seed[23:0]}, 1'b1, `VT_GROUP, `IT_GROUP,
                 grps[i]);
        end
        status(seed[6:0]);
        // Stray bits outside the command fields must not reach the wire
        cmd(32'h5cbf_8001);
        while (frag_e != 0 || gmask() != 16'h0)
            cmd(32'h0080_ffff);
        cmd(32'h0080_ffff);
        cmd(32'h0040_0000);
        cmd(32'h0000_0000);
        send({8'h02, seed[23:0]}, 1'b1, `VT_ALPHA, 3'h0, 4'h0);
        send({8'h02, seed[23:0]}, 1'b1, `VT_GROUP, `IT_GROUP, 4'h5);
        dec_on <= 1'b0;
        repeat (2) @(posedge clk);
        dec_on <= 1'b1;
        @(posedge clk);
        frag_e = 0;
        foreach (cnt_e[i]) cnt_e[i] = 0;
        check_model();
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, `OFS_STAT, 32'h0);
        chk({31'h0, er}, 32'h0);
        repeat (20) @(posedge clk);
        conclude();
    end
endmodule : test_all_frame_mode_call_tracker
